/* File: rtl/lock_pkg.sv */
package lock_pkg;
	localparam int CLK_MHZ = 20;
	// Register offsets
	localparam logic [6:0] OFS_ENABLE = 7'h01;
	localparam logic [6:0] OFS_WINDOW_OFFSET = 7'h05;
	localparam logic [6:0] OFS_PHASE_THR = 7'h06;
	localparam logic [6:0] OFS_WINDOW_CFG = 7'h07;
	localparam logic [6:0] OFS_TEST_SEL = 7'h08;
	localparam logic [6:0] OFS_REF_PERIOD = 7'h10;
	localparam logic [6:0] OFS_PHASE_ERR = 7'h11;
	localparam logic [6:0] OFS_LOCK_STATUS = 7'h12;
	// Field positions
	localparam int EN_MAIN_BIT = 6;
	localparam int EN_WDOG_BIT = 7;
	localparam int EN_WIN_BIT = 8;
	localparam int EN_PIN_BIT = 9;
	localparam int OFS_EN_BIT = 0;
	localparam int OFS_AFTER_BIT = 1;
	localparam int THR_LO_LSB = 0;
	localparam int THR_HI_LSB = 7;
	localparam int PH_CNT_LSB = 14;
	localparam int GOOD_CNT_LSB = 0;
	localparam int PULSE_W_LSB = 16;
	localparam int RING_SPEED_LSB = 19;
	localparam int RING_OBS_BIT = 21;
	localparam int ONESHOT_SEL_BIT = 22;
	localparam int STAT_WIN_BIT = 0;
	localparam int STAT_PH_BIT = 1;
	localparam int STAT_LOCK_BIT = 2;
	localparam int STAT_PIN_BIT = 3;
	localparam logic [7:0] RING_OBS_SEL = 8'hC1;
	// Reset values
	localparam logic [9:0] RST_ENABLE = 10'h3FE;
	localparam logic [23:0] RST_WINDOW_OFFSET = 24'h000000;
	localparam logic [23:0] RST_PHASE_THR = 24'h080000;
	localparam logic [23:0] RST_WINDOW_CFG = 24'h000800;
	localparam logic [23:0] RST_TEST_SEL = 24'h000001;
	// Timing
	localparam int ANALOG_WIN_NS = 10;
	localparam int ANALOG_WIN_RAW = ANALOG_WIN_NS * CLK_MHZ / 1000;
	localparam logic [7:0] ANALOG_WIN_CYC =
		8'((ANALOG_WIN_RAW < 1) ? 1 : ANALOG_WIN_RAW);
	localparam int OFFSET_NS = 100;
	localparam logic [7:0] OFFSET_CYC = 8'(OFFSET_NS * CLK_MHZ / 1000);
	localparam int WDOG_US = 50;
	localparam logic [15:0] WDOG_CYC = 16'(WDOG_US * CLK_MHZ);
endpackage

/* File: rtl/phase_meter.sv */
`timescale 1ns/1ps
module phase_meter
	import lock_pkg::*;
#(
	parameter int CNT_W = 16
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ref_evt,
	input wire logic pd_active,
	output logic [CNT_W-1:0] period,
	output logic [CNT_W-1:0] phase_err,
	output logic sample
);
	typedef struct packed {
		logic [CNT_W-1:0] run_per;
		logic [CNT_W-1:0] run_err;
		logic [CNT_W-1:0] per;
		logic [CNT_W-1:0] err;
		logic smp;
	} pm_t;
	pm_t st, next_st;
	logic [CNT_W-1:0] max_cnt;

	// Steps are clock cycles; counters saturate on a stalled reference
	always_comb
	begin
		next_st = st;
		max_cnt = '1;
		next_st.smp = 1'b0;
		if (ref_evt)
		begin
			next_st.per = st.run_per;
			next_st.err = st.run_err;
			next_st.smp = 1'b1;
			next_st.run_per = CNT_W'(1);
			next_st.run_err = CNT_W'(pd_active);
		end
		else
		begin
			if (st.run_per != max_cnt)
				next_st.run_per = st.run_per + CNT_W'(1);
			if (pd_active && st.run_err != max_cnt)
				next_st.run_err = st.run_err + CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			st <= '0;
		else
			st <= next_st;
	end

	assign period = st.per;
	assign phase_err = st.err;
	assign sample = st.smp;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_period_capture:
		assert property (ref_evt |=> period == $past(st.run_per) && sample)
		else $error("reference period not captured");
	a_error_capture:
		assert property (ref_evt |=> phase_err == $past(st.run_err))
		else $error("phase error not captured");
endmodule

/* File: rtl/pll_lock_detector.sv */
// Operation
// - One-shot select 0 gives a fixed analog window of one clock cycle (50 ns).
// - One-shot select 1 gives pulse-width ring half-periods (speed+1 cycles each) at set ring speed.
// - Ring observe bit plus selector C1h shows ring on pin; lock disabled.
// - Window lock after good-count consecutive VCO arrivals inside window.
// - Lock sets status bit 2; status register ignores writes.
// - One VCO arrival outside the window clears window lock and restarts count.
// - Offset bits 0 and 1 both set skew window to VCO after reference.
// - Offset bit 0 alone places the offset ahead of the reference.
// - Reference period measured in delay steps, readable at 10h.
// - Phase error measured with same steps, readable at 11h continuously.
// - Phase error compared to 7-bit low and high thresholds.
// - Phase lock after count field consecutive in-threshold cycles.
// - Four-bit selector picks one of sixteen test pin sources.
// - Enable bits 6, 7, 8 gate main lock, watchdog, window lock.
// - Watchdog declares unlock when no up or down pulses arrive.
// - Lock readable on test pin and in lock status register.
`timescale 1ns/1ps
module pll_lock_detector
	import lock_pkg::*;
#(
	parameter int TS_W = 16
)
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ref_in,
	input wire logic vco_in,
	input wire logic up_in,
	input wire logic dn_in,
	input wire logic reg_wr,
	input wire logic [6:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata,
	input wire logic test_pin_in,
	output logic test_pin_out,
	output logic test_pin_oe,
	output logic lock_indicator
);
	typedef struct packed {
		logic [2:0] s_ref;
		logic [2:0] s_vco;
		logic [2:0] s_up;
		logic [2:0] s_dn;
		logic [2:0] s_tp;
		logic l_ref;
		logic l_vco;
		logic l_up;
		logic l_dn;
		logic l_tp;
		logic e_ref;
		logic e_vco;
		logic [9:0] en;
		logic [23:0] ofs_cfg;
		logic [23:0] thr_cfg;
		logic [23:0] win_cfg;
		logic [23:0] sel_cfg;
		logic [TS_W-1:0] ts;
		logic [TS_W-1:0] tr;
		logic [TS_W-1:0] tv;
		logic pend;
		logic [15:0] win_cnt;
		logic win_lock;
		logic win_bad;
		logic [9:0] ph_cnt;
		logic ph_lock;
		logic [15:0] wd_cnt;
		logic wd_unlock;
		logic lock;
		logic [23:0] rdata;
		logic tp_out;
		logic tp_oe;
	} state_t;

	state_t st, next_st;
	logic [7:0] win_cycles;
	logic ring_out;
	logic shot;
	logic [15:0] period;
	logic [15:0] phase_err;
	logic sample;
	logic test_mode;
	logic signed [17:0] off;
	logic signed [17:0] late;
	logic signed [17:0] early;
	logic [15:0] sources;
	logic [15:0] good_cnt;
	logic [9:0] ph_need;
	logic [6:0] thr_lo;
	logic [6:0] thr_hi;
	logic ph_ok;
	logic win_ev;
	logic win_good;
	logic nl;

	// Distance to the reference edge lies inside +-w cycles
	function automatic logic in_win(input logic signed [17:0] d,
		input logic [7:0] w);
		logic signed [17:0] ws;
		ws = $signed({10'h000, w});
		return (d <= ws) && (d >= -ws);
	endfunction

	// Pin filter: a change counts once the 2nd and 3rd stages agree
	function automatic logic filt(input logic [2:0] s, input logic l);
		return (s[1] == s[2]) ? s[2] : l;
	endfunction

	window_oneshot u_oneshot (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.digital_sel(st.win_cfg[ONESHOT_SEL_BIT]),
		.ring_speed(st.win_cfg[RING_SPEED_LSB +: 2]),
		.pulse_width(st.win_cfg[PULSE_W_LSB +: 3]),
		.trigger(st.e_ref),
		.win_cycles(win_cycles),
		.ring_out(ring_out),
		.shot(shot)
	);

	phase_meter #(.CNT_W(16)) u_meter (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ref_evt(st.e_ref),
		.pd_active(st.l_up | st.l_dn),
		.period(period),
		.phase_err(phase_err),
		.sample(sample)
	);

	// Field decode shared by the two lock methods
	assign test_mode = st.win_cfg[RING_OBS_BIT]
		&& st.sel_cfg[7:0] == RING_OBS_SEL;
	assign good_cnt = st.win_cfg[GOOD_CNT_LSB +: 16];
	assign ph_need = st.thr_cfg[PH_CNT_LSB +: 10];
	assign thr_lo = st.thr_cfg[THR_LO_LSB +: 7];
	assign thr_hi = st.thr_cfg[THR_HI_LSB +: 7];
	assign ph_ok = phase_err >= 16'(thr_lo)
		&& phase_err <= 16'(thr_hi);

	// Offset sign: both bits place it after, bit 0 alone ahead
	always_comb
	begin
		off = '0;
		if (st.ofs_cfg[OFS_EN_BIT] && st.ofs_cfg[OFS_AFTER_BIT])
			off = $signed({10'h000, OFFSET_CYC});
		else if (st.ofs_cfg[OFS_EN_BIT])
			off = -$signed({10'h000, OFFSET_CYC});
	end

	// Late arrival measured from the last reference edge, early from
	// the VCO edge to the next one; a coincident pair is distance zero
	assign late = $signed({2'b00,
		16'(st.e_ref ? '0 : st.ts - st.tr)}) - off;
	assign early = -$signed({2'b00, 16'(st.ts - st.tv)}) - off;

	// Test pin sources in listed order, index k is entry k+1
	always_comb
	begin
		sources = 16'h0000;
		sources[0] = 1'b0;
		sources[1] = st.lock;
		sources[2] = st.l_up;
		sources[3] = st.l_dn;
		sources[4] = st.e_ref;
		sources[5] = st.l_ref;
		sources[6] = 1'b0;
		sources[7] = st.l_vco;
		sources[8] = st.l_ref;
		sources[9] = ring_out;
		sources[10] = shot;
		sources[11] = st.e_ref;
		sources[12] = 1'b1;
		sources[13] = 1'b0;
		sources[14] = st.l_vco;
		sources[15] = st.l_ref;
	end

	// Whole next state
	always_comb
	begin
		next_st = st;
		win_ev = 1'b0;
		win_good = 1'b0;
		next_st.s_ref = {st.s_ref[1:0], ref_in};
		next_st.s_vco = {st.s_vco[1:0], vco_in};
		next_st.s_up = {st.s_up[1:0], up_in};
		next_st.s_dn = {st.s_dn[1:0], dn_in};
		next_st.s_tp = {st.s_tp[1:0], test_pin_in};
		nl = filt(st.s_ref, st.l_ref);
		next_st.e_ref = nl & ~st.l_ref;
		next_st.l_ref = nl;
		nl = filt(st.s_vco, st.l_vco);
		next_st.e_vco = nl & ~st.l_vco;
		next_st.l_vco = nl;
		next_st.l_up = filt(st.s_up, st.l_up);
		next_st.l_dn = filt(st.s_dn, st.l_dn);
		next_st.l_tp = filt(st.s_tp, st.l_tp);
		next_st.ts = st.ts + TS_W'(1);

		// Register writes; read-only offsets drop the data
		if (reg_wr)
		begin
			case (reg_addr)
				OFS_ENABLE: next_st.en = reg_wdata[9:0];
				OFS_WINDOW_OFFSET: next_st.ofs_cfg = reg_wdata;
				OFS_PHASE_THR: next_st.thr_cfg = reg_wdata;
				OFS_WINDOW_CFG: next_st.win_cfg = reg_wdata;
				OFS_TEST_SEL: next_st.sel_cfg = reg_wdata;
				default: ;
			endcase
		end

		// Window judgement: late VCO judged at once, early at next ref
		if (st.e_vco)
		begin
			next_st.tv = st.ts;
			if (in_win(late, win_cycles))
			begin
				win_ev = 1'b1;
				win_good = 1'b1;
				next_st.pend = 1'b0;
			end
			else
				next_st.pend = 1'b1;
		end
		if (st.e_ref)
		begin
			next_st.tr = st.ts;
			if (st.pend && !st.e_vco)
			begin
				win_ev = 1'b1;
				win_good = in_win(early, win_cycles);
				next_st.pend = 1'b0;
			end
		end
		next_st.win_bad = win_ev && !win_good;

		// Window lock counting
		if (test_mode || !st.en[EN_WIN_BIT])
		begin
			next_st.win_cnt = 16'h0000;
			next_st.win_lock = 1'b0;
			next_st.pend = 1'b0;
		end
		else if (win_ev && !win_good)
		begin
			next_st.win_cnt = 16'h0000;
			next_st.win_lock = 1'b0;
		end
		else if (win_ev && st.win_cnt != good_cnt)
		begin
			next_st.win_cnt = st.win_cnt + 16'h0001;
			if (st.win_cnt + 16'h0001 == good_cnt)
				next_st.win_lock = 1'b1;
		end

		// Phase lock counting on each measured reference cycle
		if (test_mode)
		begin
			next_st.ph_cnt = 10'h000;
			next_st.ph_lock = 1'b0;
		end
		else if (sample && !ph_ok)
		begin
			next_st.ph_cnt = 10'h000;
			next_st.ph_lock = 1'b0;
		end
		else if (sample && st.ph_cnt != ph_need)
		begin
			next_st.ph_cnt = st.ph_cnt + 10'h001;
			if (st.ph_cnt + 10'h001 == ph_need)
				next_st.ph_lock = 1'b1;
		end

		// Watchdog: silence from the detector for too long is unlock
		if (st.l_up || st.l_dn || !st.en[EN_WDOG_BIT])
		begin
			next_st.wd_cnt = 16'h0000;
			next_st.wd_unlock = 1'b0;
		end
		else if (st.wd_cnt != WDOG_CYC)
		begin
			next_st.wd_cnt = st.wd_cnt + 16'h0001;
			if (st.wd_cnt + 16'h0001 == WDOG_CYC)
				next_st.wd_unlock = 1'b1;
		end

		// Combined flag gated by the main enable
		next_st.lock = st.en[EN_MAIN_BIT] && !test_mode
			&& !st.wd_unlock
			&& (st.win_lock || st.ph_lock);

		// Test pin; ring observe overrides the selector
		if (test_mode)
			next_st.tp_out = ring_out;
		else
			next_st.tp_out = sources[st.sel_cfg[3:0]];
		next_st.tp_oe = st.en[EN_PIN_BIT];

		// Read data registered, one cycle after the address
		case (reg_addr)
			OFS_ENABLE: next_st.rdata = {14'h0000, st.en};
			OFS_WINDOW_OFFSET: next_st.rdata = st.ofs_cfg;
			OFS_PHASE_THR: next_st.rdata = st.thr_cfg;
			OFS_WINDOW_CFG: next_st.rdata = st.win_cfg;
			OFS_TEST_SEL: next_st.rdata = st.sel_cfg;
			OFS_REF_PERIOD: next_st.rdata = {8'h00, period};
			OFS_PHASE_ERR: next_st.rdata = {8'h00, phase_err};
			OFS_LOCK_STATUS:
			begin
				next_st.rdata = 24'h000000;
				next_st.rdata[STAT_LOCK_BIT] = st.lock;
				next_st.rdata[STAT_WIN_BIT] = st.win_lock;
				next_st.rdata[STAT_PH_BIT] = st.ph_lock;
				next_st.rdata[STAT_PIN_BIT] = st.l_tp;
			end
			default: next_st.rdata = 24'h000000;
		endcase
	end

	// State register; configuration takes its reset values
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			st <= '0;
			st.en <= RST_ENABLE;
			st.ofs_cfg <= RST_WINDOW_OFFSET;
			st.thr_cfg <= RST_PHASE_THR;
			st.win_cfg <= RST_WINDOW_CFG;
			st.sel_cfg <= RST_TEST_SEL;
		end
		else
			st <= next_st;
	end

	assign reg_rdata = st.rdata;
	assign test_pin_out = st.tp_out;
	assign test_pin_oe = st.tp_oe;
	assign lock_indicator = st.lock;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence s_test_held;
		test_mode [*2];
	endsequence
	sequence s_status_read;
		!reg_wr && reg_addr == OFS_LOCK_STATUS;
	endsequence

	a_test_blocks_lock:
		assert property (s_test_held |=> !lock_indicator && !st.win_lock)
		else $error("lock active in ring observe mode");
	a_ring_on_pin:
		assert property (test_mode |=> test_pin_out == $past(ring_out))
		else $error("ring oscillator not on test pin");
	a_status_readonly:
		assert property (reg_wr && reg_addr == OFS_LOCK_STATUS
			|=> $stable(st.win_cfg) && $stable(st.thr_cfg))
		else $error("status write altered state");
	a_status_lock_bit:
		assert property (s_status_read |=> reg_rdata[STAT_LOCK_BIT]
			== $past(st.lock))
		else $error("status bit does not show lock");
	a_window_count:
		assert property ($rose(st.win_lock) |-> st.win_cnt == good_cnt)
		else $error("window lock before count reached");
	a_window_miss:
		assert property (st.win_bad |-> !st.win_lock && st.win_cnt == 0)
		else $error("miss did not clear window lock");
	a_offset_sign:
		assert property (st.ofs_cfg[1:0] == 2'b11 |-> off > 0)
		else $error("offset not after reference");
	a_offset_ahead:
		assert property (st.ofs_cfg[1:0] == 2'b01 |-> off < 0)
		else $error("offset not ahead of reference");
	a_phase_count:
		assert property ($rose(st.ph_lock) |-> st.ph_cnt == ph_need)
		else $error("phase lock before count reached");
	a_phase_out:
		assert property (sample && !ph_ok |=> !st.ph_lock)
		else $error("out of range error kept phase lock");
	a_pin_selector:
		assert property (!test_mode && st.sel_cfg[3:0] == 4'h1
			|=> test_pin_out == $past(st.lock))
		else $error("selector 1 does not show lock");
	a_main_enable:
		assert property (!st.en[EN_MAIN_BIT] |=> !lock_indicator)
		else $error("lock shown with main enable off");
	a_watchdog_trip:
		assert property ($rose(st.wd_unlock) |-> st.wd_cnt == WDOG_CYC)
		else $error("watchdog tripped at wrong count");
endmodule

/* File: rtl/window_oneshot.sv */
`timescale 1ns/1ps
module window_oneshot
	import lock_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic digital_sel,
	input wire logic [1:0] ring_speed,
	input wire logic [2:0] pulse_width,
	input wire logic trigger,
	output logic [7:0] win_cycles,
	output logic ring_out,
	output logic shot
);
	typedef struct packed {
		logic [1:0] ring_cnt;
		logic ring;
		logic [7:0] win;
		logic [7:0] shot_cnt;
		logic shot;
	} os_t;
	os_t st, next_st;
	logic [7:0] dig;

	// Ring toggles every speed+1 cycles; window is pulse_width rings
	always_comb
	begin
		next_st = st;
		dig = 8'(pulse_width) * 8'({1'b0, ring_speed} + 3'h1);
		if (st.ring_cnt == ring_speed)
		begin
			next_st.ring_cnt = 2'h0;
			next_st.ring = ~st.ring;
		end
		else
			next_st.ring_cnt = st.ring_cnt + 2'h1;
		if (digital_sel)
			next_st.win = (dig == 8'h00) ? 8'h01 : dig;
		else
			next_st.win = ANALOG_WIN_CYC;
		if (trigger)
		begin
			next_st.shot = 1'b1;
			next_st.shot_cnt = st.win;
		end
		else if (st.shot_cnt != 8'h00)
			next_st.shot_cnt = st.shot_cnt - 8'h01;
		else
			next_st.shot = 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			st <= '0;
		else
			st <= next_st;
	end

	assign win_cycles = st.win;
	assign ring_out = st.ring;
	assign shot = st.shot;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_analog_window:
		assert property (!digital_sel |=> win_cycles == ANALOG_WIN_CYC)
		else $error("analog window width wrong");
	a_digital_window:
		assert property (digital_sel && pulse_width == 3'h2
			&& ring_speed == 2'h1 |=> win_cycles == 8'h04)
		else $error("digital window width wrong");
endmodule

/* File: tb/edge_source.sv */
`timescale 1ns/1ps
module edge_source
(
	input wire logic ref_clk,
	input wire logic [7:0] period,
	input wire logic signed [7:0] vco_delay,
	input wire logic [3:0] up_width,
	output logic ref_in,
	output logic vco_in,
	output logic up_in,
	output logic dn_in
);
	logic [7:0] cnt;
	int ph;

	initial
	begin
		cnt = 8'h00;
		ref_in = 1'b0;
		vco_in = 1'b0;
		up_in = 1'b0;
		dn_in = 1'b0;
	end

	// Edges stay high three cycles, since shorter pulses may be lost
	always @(posedge ref_clk)
	begin
		ph = (int'(cnt) - int'(vco_delay) + int'(period)) % int'(period);
		cnt <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
		ref_in <= (cnt < 8'h03);
		vco_in <= (ph < 3);
		up_in <= (cnt < {4'h0, up_width});
		dn_in <= 1'b0; // Up pulse alone carries the phase error
	end
endmodule

/* File: tb/pll_lock_detector_tb.sv */
`timescale 1ns/1ps
module pll_lock_detector_tb
	import lock_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [23:0] reg_wdata = 24'h000000;
	logic test_pin_in = 1'b0;
	logic [7:0] period = 8'h14;
	logic signed [7:0] vdel = 8'sh00;
	logic [3:0] up_w = 4'h2;
	logic ref_in, vco_in, up_in, dn_in;
	logic test_pin_out, test_pin_oe, lock_indicator, last;
	logic [23:0] reg_rdata;
	logic [3:0] sels [5] = '{4'h0, 4'h6, 4'hC, 4'hD, 4'h1};
	logic exps [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	int miscompares = 0;
	int cmp_count = 0;
	int toggles;

	// 50 ns period
	always #25 ref_clk = ~ref_clk;

	edge_source partner
	(
		.ref_clk(ref_clk),
		.period(period),
		.vco_delay(vdel),
		.up_width(up_w),
		.ref_in(ref_in),
		.vco_in(vco_in),
		.up_in(up_in),
		.dn_in(dn_in)
	);

	pll_lock_detector DUT
	(
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ref_in(ref_in),
		.vco_in(vco_in),
		.up_in(up_in),
		.dn_in(dn_in),
		.reg_wr(reg_wr),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.test_pin_in(test_pin_in),
		.test_pin_out(test_pin_out),
		.test_pin_oe(test_pin_oe),
		.lock_indicator(lock_indicator)
	);

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic chk_bit(input string what, input logic exp,
		input logic got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_word(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One-cycle write strobe, taken at the second edge
	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data is valid after the edge that samples the address
	task automatic chk_reg(input string what, input logic [6:0] a,
		input logic [23:0] mask, input logic [23:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		@(posedge ref_clk);
		@(negedge ref_clk);
		chk_word(what, exp, reg_rdata & mask);
	endtask

	task automatic chk_lock(input logic exp);
		@(negedge ref_clk);
		chk_bit("lock_indicator", exp, lock_indicator);
	endtask

	// Reset clears any count left by the previous test
	task automatic setup(input logic [23:0] en, input logic [23:0] w05,
		input logic [23:0] w06, input logic [23:0] w07);
		@(posedge ref_clk);
		rstn <= 1'b0;
		wait_cyc(3);
		rstn <= 1'b1;
		wr(OFS_ENABLE, en);
		wr(OFS_WINDOW_OFFSET, w05);
		wr(OFS_PHASE_THR, w06);
		wr(OFS_WINDOW_CFG, w07);
	endtask

	// With a count of four, 30 cycles hold at most two events
	task automatic lock_seq(input logic exp);
		wait_cyc(30);
		chk_lock(1'b0);
		wait_cyc(100);
		chk_lock(exp);
	endtask

	task automatic done_test(input string name);
		$display("test %s ended, mismatches so far %0d", name, miscompares);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Whole run is about 4000 cycles
	initial
	begin
		wait_cyc(20000);
		miscompares++;
		$display("[FAIL] run time expected under 20000 cycles seen more");
		conclude();
	end

	initial
	begin
		wait_cyc(3);
		rstn <= 1'b1;
		@(negedge ref_clk);
		@(negedge ref_clk);
		chk_bit("test_pin_oe", 1'b1, test_pin_oe);
		chk_reg("enable", OFS_ENABLE, 24'hFFFFFF, 24'h0003FE);
		chk_reg("offset", OFS_WINDOW_OFFSET, 24'hFFFFFF, 24'h000000);
		chk_reg("thr", OFS_PHASE_THR, 24'hFFFFFF, 24'h080000);
		chk_reg("wcfg", OFS_WINDOW_CFG, 24'hFFFFFF, 24'h000800);
		chk_reg("sel", OFS_TEST_SEL, 24'hFFFFFF, 24'h000001);
		chk_reg("unmapped", 7'h02, 24'hFFFFFF, 24'h000000);
		// Pin level reaches status bit 3 after the three-stage filter
		@(posedge ref_clk);
		test_pin_in <= 1'b1;
		wait_cyc(5);
		chk_reg("pin input", OFS_LOCK_STATUS, 24'h000008, 24'h000008);
		done_test("reset");

		setup(24'h0003FE, 24'h000000, 24'h080000, 24'h000004);
		lock_seq(1'b1);
		chk_reg("status", OFS_LOCK_STATUS, 24'h000007, 24'h000005);
		wr(OFS_LOCK_STATUS, 24'h000000);
		chk_reg("status", OFS_LOCK_STATUS, 24'h000007, 24'h000005);
		chk_bit("test_pin_out", 1'b1, test_pin_out);
		for (int i = 0; i < 5; i++)
		begin
			wr(OFS_TEST_SEL, {20'h00000, sels[i]});
			wait_cyc(2);
			@(negedge ref_clk);
			chk_bit("pin source", exps[i], test_pin_out);
		end
		vdel <= 8'sh08;
		wait_cyc(40);
		chk_lock(1'b0);
		vdel <= 8'sh00;
		lock_seq(1'b1);
		up_w <= 4'h0;
		wait_cyc(1100);
		chk_lock(1'b0);
		done_test("window");

		setup(24'h00037E, 24'h000000, 24'h080000, 24'h000004);
		wait_cyc(1200);
		chk_lock(1'b1);
		up_w <= 4'h2;
		setup(24'h0003BE, 24'h000000, 24'h080000, 24'h000004);
		lock_seq(1'b0);
		setup(24'h0002FE, 24'h000000, 24'h080000, 24'h000004);
		lock_seq(1'b0);
		done_test("enables");

		vdel <= 8'sh02;
		setup(24'h0003FE, 24'h000000, 24'h080000, 24'h000004);
		lock_seq(1'b0);
		setup(24'h0003FE, 24'h000003, 24'h080000, 24'h000004);
		lock_seq(1'b1);
		vdel <= -8'sh02;
		setup(24'h0003FE, 24'h000001, 24'h080000, 24'h000004);
		lock_seq(1'b1);
		setup(24'h0003FE, 24'h000003, 24'h080000, 24'h000004);
		lock_seq(1'b0);
		vdel <= 8'sh03;
		setup(24'h0003FE, 24'h000000, 24'h080000, 24'h4A0004);
		lock_seq(1'b1);
		wr(OFS_WINDOW_CFG, 24'h630004);
		wr(OFS_TEST_SEL, 24'h0000C1);
		toggles = 0;
		last = test_pin_out;
		repeat (40)
		begin
			@(negedge ref_clk);
			if (test_pin_out !== last)
				toggles++;
			last = test_pin_out;
		end
		chk_bit("ring on pin", 1'b1, toggles >= 2);
		chk_lock(1'b0);
		done_test("offsets");

		vdel <= 8'sh00;
		setup(24'h0002FE, 24'h000000, 24'h010102, 24'h000800);
		wait_cyc(50);
		chk_reg("period", OFS_REF_PERIOD, 24'hFFFFFF, 24'h000014);
		chk_reg("error", OFS_PHASE_ERR, 24'hFFFFFF, 24'h000002);
		setup(24'h0002FE, 24'h000000, 24'h010102, 24'h000800);
		lock_seq(1'b1);
		chk_reg("status", OFS_LOCK_STATUS, 24'h000007, 24'h000006);
		wr(OFS_PHASE_THR, 24'h010082);
		wait_cyc(50);
		chk_lock(1'b0);
		done_test("phase");
		conclude();
	end
endmodule
